// ---- dual_channel_safe_torque_off.sv ----
/*
 * Dual channel safe torque off supervisor: drive state machine, output
 * stage enable, selectable digital outputs and an APB register slave.
 * Assumes all inputs synchronous to CLOCK_I and an APB3 master.
 */
// Added by the designer: the placing of the registers and the APB register port.
`include "sto_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module dual_channel_safe_torque_off
	import sto_pkg::*;
#(
	parameter int SKEW_CYCLES = `STO_SKEW_CYCLES,
	parameter int CNT_W = 24,
	parameter int ADDR_W = 8,
	parameter int NUM_OUT = `STO_OUTSEL_COUNT
)
(
	input wire logic CLOCK_I,
	input wire logic RST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [ADDR_W-1:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic SAFE_TORQUE_IN_A_I,
	input wire logic SAFE_TORQUE_IN_B_I,
	input wire logic START_PULSE_INPUT_I,
	input wire logic STOP_INPUT_I,
	input wire logic DRIVE_FAULT_I,
	input wire logic UNDERVOLTAGE_I,
	output logic OUTPUT_STAGE_EN_O,
	output logic [NUM_OUT-1:0] DIGITAL_OUTPUT_N_O,
	output logic [2:0] DRIVE_STATE_VIEW_O,
	output logic TORQUE_OFF_O,
	output logic MISMATCH_FAULT_O
);

	localparam int OW = `STO_OUTSEL_WIDTH;

	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------
	// Returns register index: 0 control, 1 status, 2.. output selects
	function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] addr);
		logic [ADDR_W-1:0] rel;
		rel = addr - ADDR_W'(`STO_OFF_OUTSEL0);
		reg_index = 4'hF;
		if (addr == ADDR_W'(`STO_OFF_CONTROL))
		begin
			reg_index = 4'h0;
		end
		else if (addr == ADDR_W'(`STO_OFF_STATUS))
		begin
			reg_index = 4'h1;
		end
		else if ((addr >= ADDR_W'(`STO_OFF_OUTSEL0)) && (rel[1:0] == 2'b00)
			&& ((rel >> 2) < ADDR_W'(NUM_OUT)))
		begin
			reg_index = 4'(rel >> 2) + 4'h2;
		end
	endfunction : reg_index

	// Output level for one function select code
	function automatic logic out_level(input logic [OW-1:0] sel, input logic sto,
		input logic mism, input logic fault);
		unique case (sel)
			`STO_FN_TORQUE_OFF: out_level = sto;
			`STO_FN_MISMATCH: out_level = mism;
			`STO_FN_ANY_FAULT: out_level = fault;
			`STO_FN_NO_FAULT: out_level = !fault;
			default: out_level = 1'b0;
		endcase
	endfunction : out_level

	// States in which the output stage may be switched on
	function automatic logic stage_state(input drive_state_type s);
		stage_state = (s == ST_RUN) || (s == ST_DC_BRAKE) || (s == ST_SELF_TUNING);
	endfunction : stage_state

	// ------------------------------------------------------------------
	// Channel monitor
	// ------------------------------------------------------------------
	logic in_a, in_b, mismatch;
	logic fault_reset;

	sto_channel_monitor
	#(
		.SKEW_CYCLES(SKEW_CYCLES),
		.CNT_W(CNT_W)
	)
	u_monitor
	(
		.clk_i(CLOCK_I),
		.rst_i(RST_I),
		.in_a_i(SAFE_TORQUE_IN_A_I),
		.in_b_i(SAFE_TORQUE_IN_B_I),
		.fault_reset_i(fault_reset),
		.a_o(in_a),
		.b_o(in_b),
		.mismatch_o(mismatch)
	);

	// ------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------
	logic dc_brake_q, dc_brake_d;
	logic tune_q, tune_d;
	logic config_q, config_d;
	logic [NUM_OUT-1:0][OW-1:0] outsel_q, outsel_d;
	logic [31:0] rdata_q, rdata_d;
	logic err_q, err_d;
	logic sw_start;
	logic [3:0] idx;
	logic setup, wr_access;
	drive_state_type state_q, state_d;
	logic drive_fault_q, drive_fault_d;
	logic stage_q, stage_d;
	logic [NUM_OUT-1:0] dout_q, dout_d;
	logic start_prev_q;
	logic any_fault;

	assign any_fault = mismatch || drive_fault_q;

	always_comb
	begin
		idx = reg_index(PADDR_I);
		setup = PSEL_I && !PENABLE_I;
		wr_access = PSEL_I && PENABLE_I && PWRITE_I && (idx <= 4'(NUM_OUT + 1));
		dc_brake_d = dc_brake_q;
		tune_d = tune_q;
		config_d = config_q;
		outsel_d = outsel_q;
		sw_start = 1'b0;
		fault_reset = 1'b0;
		if (wr_access && (idx == 4'h0))
		begin
			sw_start = PWDATA_I[`STO_CTRL_START];
			fault_reset = PWDATA_I[`STO_CTRL_FAULT_RESET];
			dc_brake_d = PWDATA_I[`STO_CTRL_DC_BRAKE];
			tune_d = PWDATA_I[`STO_CTRL_TUNE];
			config_d = PWDATA_I[`STO_CTRL_CONFIG];
		end
		for (int i = 0; i < NUM_OUT; i++)
		begin
			if (wr_access && (idx == 4'(i + 2)))
			begin
				outsel_d[i] = PWDATA_I[OW-1:0];
			end
		end
		rdata_d = rdata_q;
		err_d = err_q;
		if (setup)
		begin
			rdata_d = '0;
			err_d = (idx > 4'(NUM_OUT + 1));
			if (idx == 4'h0)
			begin
				rdata_d[`STO_CTRL_DC_BRAKE] = dc_brake_q;
				rdata_d[`STO_CTRL_TUNE] = tune_q;
				rdata_d[`STO_CTRL_CONFIG] = config_q;
			end
			else if (idx == 4'h1)
			begin
				rdata_d[`STO_STAT_STATE_LSB +: 3] = state_q;
				rdata_d[`STO_STAT_TORQUE_OFF] = (state_q == ST_TORQUE_OFF);
				rdata_d[`STO_STAT_MISMATCH] = mismatch;
				rdata_d[`STO_STAT_ANY_FAULT] = any_fault;
				rdata_d[`STO_STAT_IN_A] = in_a;
				rdata_d[`STO_STAT_IN_B] = in_b;
				rdata_d[`STO_STAT_STAGE_EN] = stage_q;
			end
			else if (!err_d)
			begin
				rdata_d[OW-1:0] = outsel_q[idx - 4'h2];
			end
		end
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I)
		begin
			dc_brake_q <= 1'b0;
			tune_q <= 1'b0;
			config_q <= 1'b0;
			outsel_q <= {NUM_OUT{`STO_OUTSEL_RESET}};
			rdata_q <= 32'h0000_0000;
			err_q <= 1'b0;
		end
		else
		begin
			dc_brake_q <= dc_brake_d;
			tune_q <= tune_d;
			config_q <= config_d;
			outsel_q <= outsel_d;
			rdata_q <= rdata_d;
			err_q <= err_d;
		end
	end

	assign PREADY_O = 1'b1;
	assign PRDATA_O = rdata_q;
	assign PSLVERR_O = PSEL_I && PENABLE_I && err_q;

	// ------------------------------------------------------------------
	// Drive state machine
	// ------------------------------------------------------------------
	logic both_low, both_high, start_evt;

	always_comb
	begin
		both_low = !in_a && !in_b;
		both_high = in_a && in_b;
		start_evt = (START_PULSE_INPUT_I && !start_prev_q) || sw_start;
		drive_fault_d = drive_fault_q;
		if (fault_reset)
		begin
			drive_fault_d = 1'b0;
		end
		if (DRIVE_FAULT_I)
		begin
			drive_fault_d = 1'b1;
		end
		state_d = state_q;
		if (any_fault)
		begin
			state_d = ST_FAULT;
		end
		else if (both_low)
		begin
			state_d = ST_TORQUE_OFF;
		end
		else if (state_q == ST_TORQUE_OFF)
		begin
			state_d = both_high ? ST_READY : ST_TORQUE_OFF;
		end
		else if (!both_high)
		begin
			state_d = ST_READY;
		end
		else if (UNDERVOLTAGE_I)
		begin
			state_d = ST_UNDERVOLTAGE;
		end
		else
		begin
			unique case (state_q)
				ST_READY:
				begin
					if (start_evt && STOP_INPUT_I)
					begin
						state_d = ST_RUN;
					end
					else if (tune_q)
					begin
						state_d = ST_SELF_TUNING;
					end
					else if (config_q)
					begin
						state_d = ST_CONFIG;
					end
				end
				ST_RUN:
				begin
					if (!STOP_INPUT_I)
					begin
						state_d = dc_brake_q ? ST_DC_BRAKE : ST_READY;
					end
				end
				ST_DC_BRAKE:
				begin
					if (!dc_brake_q)
					begin
						state_d = ST_READY;
					end
				end
				ST_SELF_TUNING:
				begin
					if (!tune_q)
					begin
						state_d = ST_READY;
					end
				end
				ST_CONFIG:
				begin
					if (!config_q)
					begin
						state_d = ST_READY;
					end
				end
				ST_FAULT, ST_UNDERVOLTAGE, ST_TORQUE_OFF:
				begin
					state_d = ST_READY;
				end
			endcase
		end
		stage_d = both_high && !any_fault && stage_state(state_d);
		for (int i = 0; i < NUM_OUT; i++)
		begin
			dout_d[i] = out_level(outsel_q[i], state_d == ST_TORQUE_OFF, mismatch,
				any_fault || drive_fault_d);
		end
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I)
		begin
			state_q <= ST_READY;
			drive_fault_q <= 1'b0;
			stage_q <= 1'b0;
			dout_q <= '0;
			start_prev_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			drive_fault_q <= drive_fault_d;
			stage_q <= stage_d;
			dout_q <= dout_d;
			start_prev_q <= START_PULSE_INPUT_I;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign OUTPUT_STAGE_EN_O = stage_q;
	assign DIGITAL_OUTPUT_N_O = dout_q;
	assign DRIVE_STATE_VIEW_O = state_q;
	assign TORQUE_OFF_O = (state_q == ST_TORQUE_OFF);
	assign MISMATCH_FAULT_O = mismatch;

endmodule : dual_channel_safe_torque_off

`default_nettype wire

// ---- sto_channel_monitor.sv ----
/*
 * Synchronises the two safe torque channels, counts how long they
 * disagree and latches the mismatch fault.
 * Assumes channel levels are synchronous to the clock; fault reset is a pulse.
 */
`timescale 1ns/1ns
`default_nettype none

module sto_channel_monitor
#(
	parameter int SKEW_CYCLES = 10000000,
	parameter int CNT_W = 24
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic in_a_i,
	input wire logic in_b_i,
	input wire logic fault_reset_i,
	output logic a_o,
	output logic b_o,
	output logic mismatch_o
);

	localparam logic [CNT_W-1:0] LIMIT = CNT_W'(SKEW_CYCLES);
	localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

	logic a_meta_q, a_sync_q, b_meta_q, b_sync_q;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic mism_q, mism_d;
	logic disagree, trip;

	// ------------------------------------------------------------------
	// Skew counter and fault latch
	// ------------------------------------------------------------------
	always_comb
	begin
		disagree = a_sync_q ^ b_sync_q;
		trip = disagree && (cnt_q == LIMIT);
		cnt_d = cnt_q;
		if (!disagree)
		begin
			cnt_d = '0;
		end
		else if (cnt_q != LIMIT)
		begin
			cnt_d = cnt_q + ONE;
		end
		mism_d = mism_q;
		if (fault_reset_i)
		begin
			mism_d = 1'b0;
		end
		if (trip)
		begin
			mism_d = 1'b1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			a_meta_q <= 1'b0;
			a_sync_q <= 1'b0;
			b_meta_q <= 1'b0;
			b_sync_q <= 1'b0;
			cnt_q <= '0;
			mism_q <= 1'b0;
		end
		else
		begin
			a_meta_q <= in_a_i;
			a_sync_q <= a_meta_q;
			b_meta_q <= in_b_i;
			b_sync_q <= b_meta_q;
			cnt_q <= cnt_d;
			mism_q <= mism_d;
		end
	end

	assign a_o = a_sync_q;
	assign b_o = b_sync_q;
	assign mismatch_o = mism_q;

endmodule : sto_channel_monitor

`default_nettype wire

// ---- sto_checker.sv ----
/* Assertion checker for the safe torque off block.
   Assumes it is bound to the block's top module and sees only its ports. */
`include "sto_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module sto_checker
	import sto_pkg::*;
#(
	parameter int SKEW_CYCLES = 20
)
(
	input wire logic CLOCK_I,
	input wire logic RST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic SAFE_TORQUE_IN_A_I,
	input wire logic SAFE_TORQUE_IN_B_I,
	input wire logic OUTPUT_STAGE_EN_O,
	input wire logic [2:0] DRIVE_STATE_VIEW_O,
	input wire logic TORQUE_OFF_O,
	input wire logic MISMATCH_FAULT_O
);
	// ----------------------------------------------------------------
	// Helper logic
	// ----------------------------------------------------------------
	logic [31:0] dis_q;
	logic [31:0] dis_d;
	logic long_dis;
	logic clr_wr;
	logic both_hi;
	assign long_dis = dis_q >= 32'(SKEW_CYCLES);
	assign both_hi = SAFE_TORQUE_IN_A_I && SAFE_TORQUE_IN_B_I;
	assign clr_wr = PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == `STO_OFF_CONTROL
		&& PWDATA_I[`STO_CTRL_FAULT_RESET];
	always_comb
	begin
		dis_d = 32'h0000_0000;
		if (SAFE_TORQUE_IN_A_I != SAFE_TORQUE_IN_B_I)
			dis_d = (dis_q < 32'h0000_1000) ? dis_q + 32'h0000_0001 : dis_q;
	end
	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I)
			dis_q <= 32'h0000_0000;
		else
			dis_q <= dis_d;
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (RST_I);

	a_off_stage_low: assert property (TORQUE_OFF_O |-> !OUTPUT_STAGE_EN_O)
		else $error("stage enabled in torque off");
	a_mism_stage_low: assert property (MISMATCH_FAULT_O |-> !OUTPUT_STAGE_EN_O)
		else $error("stage enabled with mismatch");
	a_fault_clear_only: assert property ($fell(MISMATCH_FAULT_O) |->
		$past(clr_wr, 1) || $past(clr_wr, 2))
		else $error("mismatch cleared without fault reset");
	a_low_gives_off: assert property ((!SAFE_TORQUE_IN_A_I && !SAFE_TORQUE_IN_B_I)[*5] |->
		TORQUE_OFF_O || DRIVE_STATE_VIEW_O == ST_FAULT)
		else $error("both channels low without torque off");
	a_leave_both_high: assert property ($fell(TORQUE_OFF_O) |-> $past(both_hi, 2)
		|| $past(both_hi, 3) || DRIVE_STATE_VIEW_O == ST_FAULT)
		else $error("torque off left without both channels");
	a_skew_trips: assert property (dis_q > 32'(SKEW_CYCLES + 5) |-> MISMATCH_FAULT_O)
		else $error("long skew without mismatch");
	a_no_early_trip: assert property ($rose(MISMATCH_FAULT_O) |-> $past(long_dis, 1)
		|| $past(long_dis, 2) || $past(long_dis, 3))
		else $error("mismatch tripped on short skew");
	a_state_code: assert property (DRIVE_STATE_VIEW_O == ST_RUN |-> OUTPUT_STAGE_EN_O)
		else $error("run state reported with stage off");
	a_run_needs_high: assert property ($rose(OUTPUT_STAGE_EN_O) |->
		(DRIVE_STATE_VIEW_O == ST_RUN || DRIVE_STATE_VIEW_O == ST_SELF_TUNING)
		&& $past(both_hi, 1))
		else $error("stage enabled without both channels");

	c_off: cover property ($rose(TORQUE_OFF_O));
	c_mism: cover property ($rose(MISMATCH_FAULT_O));
	c_run: cover property ($rose(OUTPUT_STAGE_EN_O));
	c_clear: cover property ($fell(MISMATCH_FAULT_O));
endmodule : sto_checker

bind dual_channel_safe_torque_off sto_checker #(.SKEW_CYCLES(SKEW_CYCLES)) i_sto_checker
(
	.CLOCK_I(CLOCK_I), .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
	.PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
	.SAFE_TORQUE_IN_A_I(SAFE_TORQUE_IN_A_I), .SAFE_TORQUE_IN_B_I(SAFE_TORQUE_IN_B_I),
	.OUTPUT_STAGE_EN_O(OUTPUT_STAGE_EN_O), .DRIVE_STATE_VIEW_O(DRIVE_STATE_VIEW_O),
	.TORQUE_OFF_O(TORQUE_OFF_O), .MISMATCH_FAULT_O(MISMATCH_FAULT_O)
);

`default_nettype wire

// ---- sto_consts.svh ----
/*
 * Constants of the dual channel safe torque off block: register offsets,
 * field positions, reset values, output function codes and timing counts.
 * Assumes a 100 MHz system clock and a 32-bit APB register bus.
 */
// Overview of operation
// - Both channels low: hold torque-off state, ignore run and motion commands; code goes to ST_FAULT instead while any fault is latched.
// - Leave torque-off only when both channels are high together; code also leaves it for ST_FAULT on any latched fault.
// - One channel high, other low: trip mismatch fault, disable output stage.
// - Mismatch fault stays latched; only an explicit fault reset clears it.
// - Both channels high: torque-off inactive, run and stop accepted normally.
// - Channels must change within 100 ms; longer skew raises mismatch fault.
// - Torque-off overrides every other function; nothing else enables the stage. Code lets a latched fault override it (ST_FAULT).
// - Drive state reported as one of eight states, readable in state view.
// - Each of five digital outputs selects torque-off, mismatch or fault signal.
// - Select 33: output on while torque-off state is active.
// - Select 34: output on while mismatch fault is present.
// - Select 13: output on whenever any drive fault is active.
// - Select 26: output on while the drive is not faulted.
// - Restart: restore both channels, then pulse start; motor starts on pulse.
`ifndef STO_CONSTS_SVH
`define STO_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define STO_OFF_CONTROL 8'h00
`define STO_OFF_STATUS 8'h04
`define STO_OFF_OUTSEL0 8'h08
`define STO_OUTSEL_COUNT 5

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define STO_CTRL_START 0
`define STO_CTRL_FAULT_RESET 1
`define STO_CTRL_DC_BRAKE 2
`define STO_CTRL_TUNE 3
`define STO_CTRL_CONFIG 4

// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define STO_STAT_STATE_LSB 0
`define STO_STAT_TORQUE_OFF 3
`define STO_STAT_MISMATCH 4
`define STO_STAT_ANY_FAULT 5
`define STO_STAT_IN_A 6
`define STO_STAT_IN_B 7
`define STO_STAT_STAGE_EN 8

// ----------------------------------------------------------------------
// Reset values and output function codes
// ----------------------------------------------------------------------
`define STO_OUTSEL_WIDTH 6
`define STO_OUTSEL_RESET 6'h00
`define STO_FN_TORQUE_OFF 6'h21
`define STO_FN_MISMATCH 6'h22
`define STO_FN_ANY_FAULT 6'h0D
`define STO_FN_NO_FAULT 6'h1A

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define STO_CLOCK_HZ 100000000
`define STO_SKEW_LIMIT_MS 100
`define STO_SKEW_CYCLES (`STO_SKEW_LIMIT_MS * (`STO_CLOCK_HZ / 1000))

`endif

// ---- sto_pkg.sv ----
/*
 * Types shared by the safe torque off block.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package sto_pkg;

	// ------------------------------------------------------------------
	// Drive state, Gray coded along ready, run, brake, torque off
	// ------------------------------------------------------------------
	typedef enum logic [2:0]
	{
		ST_READY = 3'h0,
		ST_RUN = 3'h1,
		ST_DC_BRAKE = 3'h3,
		ST_TORQUE_OFF = 3'h2,
		ST_FAULT = 3'h6,
		ST_UNDERVOLTAGE = 3'h7,
		ST_SELF_TUNING = 3'h5,
		ST_CONFIG = 3'h4
	} drive_state_type;

endpackage : sto_pkg

`default_nettype wire

// ---- sto_safety_relay.sv ----
/* Model of the external safety relay feeding both channels and the stop input.
   Assumes the bench calls its tasks; levels change just after a clock edge. */
`timescale 1ns/1ns
`default_nettype none

module sto_safety_relay
(
	input wire logic clk_i,
	output logic path_a_o,
	output logic path_b_o,
	output logic stop_o
);
	initial
	begin
		path_a_o = 1'b0;
		path_b_o = 1'b0;
		stop_o = 1'b1;
	end
	task set_paths(input logic lvl, input int skew);
		@(posedge clk_i);
		path_a_o <= lvl;
		repeat (skew) @(posedge clk_i);
		path_b_o <= lvl;
	endtask : set_paths
	task controlled_stop(input int ramp, input int skew);
		@(posedge clk_i);
		stop_o <= 1'b0;
		repeat (ramp) @(posedge clk_i);
		set_paths(1'b0, skew);
	endtask : controlled_stop
	task open_stop();
		@(posedge clk_i);
		stop_o <= 1'b0;
	endtask : open_stop
	task restore(input int skew);
		set_paths(1'b1, skew);
		@(posedge clk_i);
		stop_o <= 1'b1;
	endtask : restore
endmodule : sto_safety_relay

`default_nettype wire

// ---- tb_dual_channel_safe_torque_off.sv ----
/* Self-checking bench for the safe torque off block.
   Assumes the relay model drives the channels and an APB master of its own. */
`include "sto_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module tb_dual_channel_safe_torque_off
	import sto_pkg::*;
;
	localparam int SKEW = 20;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [7:0] padr = 8'h00;
	logic [31:0] pwd = 32'h0000_0000;
	logic [31:0] prd;
	logic prdy;
	logic perr;
	logic ina;
	logic inb;
	logic stp;
	logic start = 1'b0;
	logic dflt = 1'b0;
	logic uv = 1'b0;
	logic stage;
	logic [4:0] dout;
	logic [2:0] st;
	logic toff;
	logic mism;
	logic [31:0] rd;
	logic er;
	int checks = 0;
	int miscompares = 0;
	logic [5:0] fn [5] = '{`STO_FN_TORQUE_OFF, `STO_FN_MISMATCH, `STO_FN_ANY_FAULT,
		`STO_FN_NO_FAULT, `STO_OUTSEL_RESET};

	dual_channel_safe_torque_off #(.SKEW_CYCLES(SKEW)) i_dual_channel_safe_torque_off
	(
		.CLOCK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
		.PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
		.SAFE_TORQUE_IN_A_I(ina), .SAFE_TORQUE_IN_B_I(inb), .START_PULSE_INPUT_I(start),
		.STOP_INPUT_I(stp), .DRIVE_FAULT_I(dflt), .UNDERVOLTAGE_I(uv),
		.OUTPUT_STAGE_EN_O(stage), .DIGITAL_OUTPUT_N_O(dout), .DRIVE_STATE_VIEW_O(st),
		.TORQUE_OFF_O(toff), .MISMATCH_FAULT_O(mism)
	);
	sto_safety_relay i_sto_safety_relay
	(
		.clk_i(clk), .path_a_o(ina), .path_b_o(inb), .stop_o(stp)
	);

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task final_report();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : final_report
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do
		begin
			@(posedge clk);
		end
		while (prdy !== 1'b1);
		rd = prd;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wt
	task pulse();
		@(posedge clk);
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
	endtask : pulse

	// ----------------------------------------------------------------
	// Clock, watchdog and tests
	// ----------------------------------------------------------------
	initial
	begin
		forever #5 clk = ~clk;
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		miscompares++;
		final_report();
	end
	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		wt(6);
		chk("state", ST_TORQUE_OFF, st);
		chk("toff", 1, toff);
		pulse();
		wt(3);
		chk("stage", 0, stage);
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b1, 8'(`STO_OFF_OUTSEL0 + 4 * i), 32'(fn[i]));
			apb(1'b0, 8'(`STO_OFF_OUTSEL0 + 4 * i), 0);
			chk("outsel", 32'(fn[i]), rd);
		end
		apb(1'b0, `STO_OFF_STATUS, 0);
		chk("status", 32'h0000_000A, rd);
		apb(1'b0, 8'h40, 0);
		chk("slverr", 1, er);
		wt(2);
		chk("dout", 5'b01001, dout);
		i_sto_safety_relay.restore(0);
		wt(6);
		chk("state", ST_READY, st);
		chk("toff", 0, toff);
		chk("dout", 5'b01000, dout);
		pulse();
		wt(3);
		chk("stage", 1, stage);
		chk("state", ST_RUN, st);
		apb(1'b0, `STO_OFF_STATUS, 0);
		chk("status", 32'h0000_01C1, rd);
		i_sto_safety_relay.controlled_stop(10, 5);
		wt(6);
		chk("state", ST_TORQUE_OFF, st);
		chk("mism", 0, mism);
		i_sto_safety_relay.restore(2 * SKEW);
		wt(6);
		chk("mism", 1, mism);
		chk("state", ST_FAULT, st);
		chk("stage", 0, stage);
		chk("dout", 5'b00110, dout);
		apb(1'b0, `STO_OFF_STATUS, 0);
		chk("status", 32'h0000_00F6, rd);
		apb(1'b1, `STO_OFF_CONTROL, 32'h0000_0002);
		wt(3);
		chk("mism", 0, mism);
		chk("state", ST_READY, st);
		@(posedge clk);
		dflt <= 1'b1;
		wt(3);
		chk("dout", 5'b00100, dout);
		chk("state", ST_FAULT, st);
		@(posedge clk);
		dflt <= 1'b0;
		apb(1'b1, `STO_OFF_CONTROL, 32'h0000_0002);
		wt(3);
		chk("state", ST_READY, st);
		apb(1'b1, `STO_OFF_CONTROL, 32'h0000_0004);
		apb(1'b0, `STO_OFF_CONTROL, 0);
		chk("ctrl", 32'h0000_0004, rd);
		pulse();
		wt(3);
		i_sto_safety_relay.open_stop();
		wt(3);
		chk("state", ST_DC_BRAKE, st);
		chk("stage", 1, stage);
		apb(1'b1, `STO_OFF_CONTROL, 32'h0000_0008);
		wt(3);
		chk("state", ST_SELF_TUNING, st);
		chk("stage", 1, stage);
		apb(1'b1, `STO_OFF_CONTROL, 32'h0000_0010);
		wt(3);
		chk("state", ST_CONFIG, st);
		chk("stage", 0, stage);
		apb(1'b1, `STO_OFF_CONTROL, 32'h0000_0000);
		@(posedge clk);
		uv <= 1'b1;
		wt(3);
		chk("state", ST_UNDERVOLTAGE, st);
		@(posedge clk);
		uv <= 1'b0;
		i_sto_safety_relay.restore(0);
		apb(1'b1, `STO_OFF_CONTROL, 32'h0000_0001);
		wt(2);
		chk("state", ST_RUN, st);
		final_report();
	end
endmodule : tb_dual_channel_safe_torque_off

`default_nettype wire
